// ### rtl/pacfg_pkg.sv
// Package with register map, field layout and reset values for the port config block
package pacfg_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [11:0] PACFG_PULLUP_ADDR  = 12'h000;
    localparam logic [11:0] PACFG_CHANGE_ADDR  = 12'h004;
    localparam logic [11:0] PACFG_CONFIG_ADDR  = 12'h008;
    localparam logic [11:0] PACFG_STATUS_ADDR  = 12'h00C;
    localparam logic [11:0] PACFG_MASK_ADDR    = 12'h010;
    localparam logic [11:0] PACFG_PINS_ADDR    = 12'h014;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int          PACFG_PIN_COUNT     = 6;
    localparam logic [7:0]  PACFG_PULLUP_IMPL   = 8'h37;
    localparam logic [7:0]  PACFG_CHANGE_IMPL   = 8'h3F;
    localparam logic [7:0]  PACFG_OSC_PINS      = 8'h30;
    localparam int          PACFG_CFG_OSC_LSB   = 0;
    localparam int          PACFG_CFG_MASTER_CLEAR_BIT  = 3;
    localparam int          PACFG_CFG_GLOBAL_INT_EN_BIT = 4;
    localparam int          PACFG_PIN_THREE             = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  PACFG_PULLUP_RESET  = 8'h37;
    localparam logic [7:0]  PACFG_CHANGE_RESET  = 8'h00;
    localparam logic [4:0]  PACFG_CONFIG_RESET  = 5'h00;
    localparam logic [5:0]  PACFG_MASK_RESET    = 6'h00;

    // ****************************************************************
    // Oscillator mode encodings
    // ****************************************************************
    localparam logic [2:0]  PACFG_OSC_LOW_POWER  = 3'h0;
    localparam logic [2:0]  PACFG_OSC_STANDARD   = 3'h1;
    localparam logic [2:0]  PACFG_OSC_HIGH_SPEED = 3'h2;

endpackage

// ### rtl/pacfg_change_detect.sv
// Pin synchroniser and per-pin change detector
`timescale 1ns/10ps
`default_nettype none
module pacfg_change_detect
    import pacfg_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pins_in,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] pins_stable,
    output logic      [WIDTH-1:0] change_pulse
);

    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] sync3_reg;
    logic [WIDTH-1:0] stable_reg;

    // Three-stage synchroniser, first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Accept a level once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_reg <= '0;
        end else begin
            stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
        end
    end

    assign pins_stable = stable_reg;

    assign change_pulse = enable & (((sync2_reg & sync3_reg) & ~stable_reg)
                                  | ((~sync2_reg & ~sync3_reg) & stable_reg));

endmodule
`default_nettype wire

// ### rtl/pacfg_top.sv
// Port pull-up and change-interrupt configuration with APB register access
//
// Function
// - Unused pull-up bits 7, 6 and 3 and change-enable bits 7 and 6 read zero and drop writes.
// - Each change-enable bit 5..0 turns change detection on its pin on or off.
// - In a crystal oscillator mode change-enable bits 5 and 4 read as one.
// - In a crystal oscillator mode pull-up bits 5 and 4 read as one whatever was written.
// - Pin three has its pull-up on when used as master clear, off when used as an input.
// - A change interrupt reaches the processor only while global interrupt enable is set.
`timescale 1ns/10ps
`default_nettype none
module pacfg_top
    import pacfg_pkg::*;
#(
    parameter int PINS = PACFG_PIN_COUNT
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [PINS-1:0] port_pins_in,
    output logic      [PINS-1:0] pullup_enable,
    output logic                 irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]      pullup_reg;
    logic [7:0]      change_reg;
    logic [4:0]      config_reg;
    logic [PINS-1:0] status_reg;
    logic [PINS-1:0] status_next;
    logic [PINS-1:0] mask_reg;
    logic [PINS-1:0] pullup_out_reg;
    logic            irq_reg;
    logic [31:0]     prdata_reg;
    logic            pready_reg;
    logic            pslverr_reg;
    logic [PINS-1:0] pins_stable;
    logic [PINS-1:0] change_pulse;
    logic            osc_crystal;
    logic [7:0]      pullup_view;
    logic [7:0]      change_view;
    logic            wr_access;
    logic            rd_access;
    logic [PINS-1:0] pending;

    // Crystal mode decode, shared by both views
    function automatic logic is_crystal(input logic [2:0] mode);
        return (mode == PACFG_OSC_LOW_POWER) || (mode == PACFG_OSC_STANDARD)
            || (mode == PACFG_OSC_HIGH_SPEED);
    endfunction

    // Decode address match against a register offset
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] offs);
        return addr == offs;
    endfunction

    assign osc_crystal = is_crystal(config_reg[PACFG_CFG_OSC_LSB +: 3]);

    // ****************************************************************
    // Register views
    // ****************************************************************
    // pull-up bits 5:4 forced in crystal modes
    assign pullup_view = (pullup_reg & PACFG_PULLUP_IMPL)
                       | (osc_crystal ? PACFG_OSC_PINS : 8'h00);
    // change bits 5:4 forced in crystal modes
    assign change_view = (change_reg & PACFG_CHANGE_IMPL)
                       | (osc_crystal ? PACFG_OSC_PINS : 8'h00);

    // Reads are captured in the first access cycle; writes land only at the
    // completing edge, so a stalled master never commits early
    assign wr_access = psel && penable && pwrite && pready_reg;
    assign rd_access = psel && penable && !pwrite && !pready_reg;

    // ****************************************************************
    // Change detection
    // ****************************************************************
    pacfg_change_detect #(
        .WIDTH        (PINS)
    ) u_detect (
        .pclk         (pclk),
        .presetn      (presetn),
        .pins_in      (port_pins_in),
        .enable       (change_reg[PINS-1:0]),
        .pins_stable  (pins_stable),
        .change_pulse (change_pulse)
    );

    // ****************************************************************
    // Software registers
    // ****************************************************************
    // unimplemented bits never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_reg <= PACFG_PULLUP_RESET;
            change_reg <= PACFG_CHANGE_RESET;
            config_reg <= PACFG_CONFIG_RESET;
            mask_reg   <= PACFG_MASK_RESET;
        end else if (wr_access) begin
            if (hit(paddr, PACFG_PULLUP_ADDR)) begin
                pullup_reg <= pwdata[7:0] & PACFG_PULLUP_IMPL;
            end
            if (hit(paddr, PACFG_CHANGE_ADDR)) begin
                change_reg <= pwdata[7:0] & PACFG_CHANGE_IMPL;
            end
            if (hit(paddr, PACFG_CONFIG_ADDR)) begin
                config_reg <= pwdata[4:0];
            end
            if (hit(paddr, PACFG_MASK_ADDR)) begin
                mask_reg <= pwdata[PINS-1:0];
            end
        end
    end

    // Sticky change flags; a new event beats a write-one clear
    always_comb begin
        status_next = status_reg;
        if (wr_access && hit(paddr, PACFG_STATUS_ADDR)) begin
            status_next = status_next & ~pwdata[PINS-1:0];
        end
        status_next = status_next | change_pulse;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pending = status_reg & mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (|pending) && config_reg[PACFG_CFG_GLOBAL_INT_EN_BIT];
        end
    end

    // Pull-up drive; pin three follows the master clear setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_out_reg <= '0;
        end else begin
            pullup_out_reg <= pullup_view[PINS-1:0];
            // pin three pull-up from master clear setting
            pullup_out_reg[PACFG_PIN_THREE] <= config_reg[PACFG_CFG_MASTER_CLEAR_BIT];
        end
    end

    assign pullup_enable = pullup_out_reg;
    assign irq           = irq_reg;

    // ****************************************************************
    // APB response
    // ****************************************************************
    // One answer after a single wait state; unmapped reads give zero with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
            if (psel && penable && !pready_reg) begin
                pslverr_reg <= !(hit(paddr, PACFG_PULLUP_ADDR) || hit(paddr, PACFG_CHANGE_ADDR)
                              || hit(paddr, PACFG_CONFIG_ADDR) || hit(paddr, PACFG_STATUS_ADDR)
                              || hit(paddr, PACFG_MASK_ADDR) || hit(paddr, PACFG_PINS_ADDR));
            end
            if (rd_access) begin
                case (paddr)
                    PACFG_PULLUP_ADDR: prdata_reg <= {24'h000000, pullup_view};
                    PACFG_CHANGE_ADDR: prdata_reg <= {24'h000000, change_view};
                    PACFG_CONFIG_ADDR: prdata_reg <= {27'h0000000, config_reg};
                    PACFG_STATUS_ADDR: prdata_reg <= {26'h0000000, status_reg};
                    PACFG_MASK_ADDR:   prdata_reg <= {26'h0000000, mask_reg};
                    PACFG_PINS_ADDR:   prdata_reg <= {26'h0000000, pins_stable};
                    default:           prdata_reg <= '0;
                endcase
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // reserved pull-up bits read zero
    pullup_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pullup_view & ~PACFG_PULLUP_IMPL) == 8'h00)
        else $error("reserved pull-up bits set");

    change_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (change_pulse & ~change_reg[PINS-1:0]) == '0)
        else $error("change flagged on disabled pin");

    change_crystal_a: assert property (@(posedge pclk) disable iff (!presetn)
        osc_crystal |-> change_view[5:4] == 2'b11)
        else $error("change bits not forced in crystal mode");

    pullup_crystal_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && osc_crystal && $stable(osc_crystal) |=> pullup_enable[5:4] == 2'b11)
        else $error("pull-up bits not forced in crystal mode");

    // pin three pull-up follows master clear
    pin_three_pullup_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pullup_enable[PACFG_PIN_THREE] == $past(config_reg[PACFG_CFG_MASTER_CLEAR_BIT]))
        else $error("pin three pull-up mismatch");

    irq_global_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(config_reg[PACFG_CFG_GLOBAL_INT_EN_BIT]) |-> !irq)
        else $error("interrupt without global enable");

    pullup_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        !osc_crystal |=> pullup_enable[2:0] == $past(pullup_reg[2:0]))
        else $error("pull-up output mismatch");

    // Change event always sets its sticky flag next cycle
    status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        |change_pulse |=> (status_reg & $past(change_pulse)) == $past(change_pulse))
        else $error("change event lost");

    // APB answer one cycle into access
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");

    // unmasked flag with global enable raises the line
    irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|pending) && config_reg[PACFG_CFG_GLOBAL_INT_EN_BIT] |=> irq)
        else $error("interrupt not raised");

    // Line drops once nothing unmasked is pending
    irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(|pending) |=> !irq)
        else $error("interrupt without pending flag");

    // pull-up read pads unused bits with zero
    pullup_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == PACFG_PULLUP_ADDR |=> prdata[31:6] == 26'h0 && !prdata[3])
        else $error("pull-up read shows unused bits");

    // change-enable read pads unused bits with zero
    change_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == PACFG_CHANGE_ADDR |=> prdata[31:6] == 26'h0)
        else $error("change-enable read shows unused bits");

    // crystal mode reads back ones in bits 5:4
    crystal_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && osc_crystal && (paddr == PACFG_PULLUP_ADDR || paddr == PACFG_CHANGE_ADDR)
        |=> prdata[5:4] == 2'b11)
        else $error("crystal read-back not forced");

    pullup_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == PACFG_PULLUP_ADDR |=> pullup_reg[7:6] == 2'b00 && !pullup_reg[3])
        else $error("unused pull-up bit stored");

    // Refused transfers hand back zero data
    refused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused transfer returned data");

    // Answer lasts a single cycle
    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("apb answer held too long");

    // Write-one clear empties the written flags when no event competes
    status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == PACFG_STATUS_ADDR && !(|change_pulse)
        |=> (status_reg & $past(pwdata[PINS-1:0])) == '0)
        else $error("status flag not cleared");

    // Flags hold without events or writes
    status_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_access && !(|change_pulse) |=> status_reg == $past(status_reg))
        else $error("status flag changed unprompted");

    // Pin level read pads upper bits with zero
    pins_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == PACFG_PINS_ADDR |=> prdata[31:PINS] == '0)
        else $error("pin level read shows upper bits");

endmodule
`default_nettype wire

// ### verification/test_port_a_pullup_and_change_config.sv
// Self-checking bench for the port pull-up and change-interrupt configuration block
`timescale 1ns/10ps
`default_nettype none
module test_port_a_pullup_and_change_config
    import pacfg_pkg::*;
;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    typedef struct {
        logic [31:0] exp;
        logic        err;
        bit          chk;
    } pacfg_note_type;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  port_pins_in;
    logic [5:0]  pullup_enable;
    logic        irq;
    int          error_cnt;
    int          tests_run;
    integer      seed;
    pacfg_note_type notes[$];

    pacfg_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_pins_in(port_pins_in),
        .pullup_enable(pullup_enable), .irq(irq)
    );

    // Free-running 10 MHz clock
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the note is queued before the request goes out
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er, input bit ck);
        int n;
        notes.push_back('{exp: e, err: er, chk: ck});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Bounded wait: a slave that never answers ends the run
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            finish_test();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0000_0000, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, e, 1'b0, 1'b1);
    endtask

    task automatic wait_irq(input logic v);
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (irq === v) break;
        end
        check("irq", {31'h0, v}, {31'h0, irq});
        // A line that never settles ends the run
        if (irq !== v) finish_test();
    endtask

    // ****************************************************************
    // Output watcher: each answer retires the oldest note
    // ****************************************************************
    always @(posedge pclk) begin
        pacfg_note_type nt;
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected pready", 32'h0, 32'h1);
            end else begin
                nt = notes.pop_front();
                check("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
                if (nt.chk) check("prdata", nt.exp, prdata);
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] pu;
        logic [31:0] ch;
        logic [31:0] xt;
        logic        mc;
        seed = 27804;
        error_cnt = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        port_pins_in = 6'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state; config reset selects low-power crystal, so bits 5:4 forced
        rd(PACFG_PULLUP_ADDR, 32'h0000_0037);
        rd(PACFG_CHANGE_ADDR, 32'h0000_0030);
        rd(PACFG_MASK_ADDR, 32'h0000_0000);
        rd(PACFG_STATUS_ADDR, 32'h0000_0000);
        check("pullup_enable", 32'h0000_0037, {26'h0, pullup_enable});
        // Every oscillator mode, random data with upper bits set too
        for (int m = 0; m < 8; m++) begin
            pu = $random(seed);
            ch = $random(seed);
            mc = m[1];
            xt = (m < 3) ? 32'h0000_0030 : 32'h0000_0000;
            wr(PACFG_CONFIG_ADDR, {28'h0, mc, m[2:0]});
            wr(PACFG_PULLUP_ADDR, pu);
            wr(PACFG_CHANGE_ADDR, ch);
            rd(PACFG_PULLUP_ADDR, (pu & 32'h0000_0037) | xt);
            rd(PACFG_CHANGE_ADDR, (ch & 32'h0000_003F) | xt);
            repeat (2) @(posedge pclk);
            check("pullup_enable", (pu & 32'h37) | xt | {28'h0, mc, 3'h0},
                  {26'h0, pullup_enable});
        end
        // Unmapped places are refused
        apb(1'b0, 12'h018, 32'h0, 32'h0000_0000, 1'b1, 1'b1);
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, 32'h0, 1'b1, 1'b0);
        // Change on pin 0 enabled, pin 1 disabled, global enable off
        wr(PACFG_CONFIG_ADDR, 32'h0000_0003);
        wr(PACFG_CHANGE_ADDR, 32'h0000_0001);
        wr(PACFG_MASK_ADDR, 32'h0000_0001);
        @(posedge pclk);
        port_pins_in <= 6'h03;
        repeat (10) @(posedge pclk);
        rd(PACFG_STATUS_ADDR, 32'h0000_0001);
        rd(PACFG_PINS_ADDR, 32'h0000_0003);
        check("irq", 32'h0, {31'h0, irq});
        wr(PACFG_CONFIG_ADDR, 32'h0000_0013);
        wait_irq(1'b1);
        wr(PACFG_MASK_ADDR, 32'h0000_0000);
        wait_irq(1'b0);
        wr(PACFG_MASK_ADDR, 32'h0000_0001);
        wait_irq(1'b1);
        wr(PACFG_STATUS_ADDR, 32'h0000_0001);
        wait_irq(1'b0);
        rd(PACFG_STATUS_ADDR, 32'h0000_0000);
        // Falling edge counts as a change too
        port_pins_in <= 6'h00;
        wait_irq(1'b1);
        rd(PACFG_STATUS_ADDR, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        finish_test();
    end
endmodule
`default_nettype wire
